// ==== design/pin_sync.v ====
// Two-flop synchroniser for a bus of asynchronous inputs.
// Assumes inputs come from pins outside the core clock domain.
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
	parameter W = 4
) (
	input  wire         core_clk,
	input  wire         resetn,
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] meta_reg;

	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta_reg <= {W{1'b0}};
			sync_out <= {W{1'b0}};
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ==== design/pmu_serial_consts.vh ====
// Constants for the serial write port and reset sequencer.
// Assumes a 100 MHz core clock; included by bare name.
`ifndef PMU_SERIAL_CONSTS_VH
`define PMU_SERIAL_CONSTS_VH
`define CLK_PERIOD_NS      10
`define WORD_BITS          29
`define SHIFT_BITS         32
`define SHIFT_CNT_W        6
`define INIT_TIME_US       600
`define INIT_CYCLES        ((`INIT_TIME_US * 1000) / `CLK_PERIOD_NS)
`define BUSY_TIME_NS       270
`define BUSY_CYCLES        (`BUSY_TIME_NS / `CLK_PERIOD_NS)
`define ADDR_MSB           28
`define ADDR_LSB           22
`define ADDR_W             7
`define DATA_W             22
`define GAIN_ADDR          7'h01
`define GAIN_BIT           0
`define READBACK_BIT       28
`define GAIN_RESET         1'b1
`define REG_COUNT          4
`define REG_RESET          22'h000000
`endif

// ==== design/pmu_serial_write_and_reset.v ====
// Serial write port, readback and reset sequencing of the measurement unit.
// Assumes serial pins are asynchronous and sampled by core_clk (much faster).
`timescale 1ns/1ns
`default_nettype none
`include "pmu_serial_consts.vh"

module pmu_serial_write_and_reset #(
	parameter INIT_CYCLES = `INIT_CYCLES
) (
	input  wire        core_clk,
	input  wire        resetn,
	input  wire        link_sel,
	input  wire        frame_n,
	input  wire        frame_n_c,
	input  wire        sclk,
	input  wire        sclk_c,
	input  wire        sdi,
	input  wire        sdi_c,
	output reg         sdo,
	output reg         sdo_c,
	output reg         sdo_oe,
	input  wire        reset_pin_n,
	input  wire        busy_n_in,
	output wire        busy_n_out,
	output wire        busy_n_oe,
	output reg         current_sense_gain,
	output reg         wr_strobe,
	output reg  [6:0]  wr_addr,
	output reg  [21:0] wr_data
);
	localparam ST_INIT  = 4'b0001;
	localparam ST_IDLE  = 4'b0010;
	localparam ST_SHIFT = 4'b0100;
	localparam ST_BUSY  = 4'b1000;
	// Busy after a write frame lasts a fixed time
	localparam [31:0] BUSY_CNT = `BUSY_CYCLES;

	wire [8:0] pins_sync;
	reg        strap_reg;
	reg  [3:0] state_reg;
	reg  [3:0] state_next;
	reg  [`SHIFT_BITS-1:0]  shift_reg;
	reg  [`SHIFT_CNT_W-1:0] bits_reg;
	reg  [19:0] count_reg;
	reg         sclk_d_reg;
	reg         frame_d_reg;
	reg         rst_d_reg;
	reg         rd_pend_reg;
	reg         link_active_reg;
	reg  [`SHIFT_BITS-1:0] rd_shift_reg;
	// Small register store, cleared by every reset
	reg  [`DATA_W-1:0] regs_mem [0:`REG_COUNT-1];

	// Synchronised link levels and their edges
	reg         sclk_s;
	reg         frame_s;
	reg         sdi_s;
	wire        rst_s;
	wire        sclk_fall;
	wire        sclk_rise;
	wire        frame_fall;
	wire        frame_rise;
	wire        rst_fall;

	// Frame decode
	wire [`ADDR_W-1:0] cmd_addr;
	wire        cmd_read;
	wire        take_word;
	integer     i;

	pin_sync #(
		.W(9)
	) u_sync (
		.core_clk(core_clk),
		.resetn  (resetn),
		.async_in({link_sel, busy_n_in, reset_pin_n, sdi_c, sdi, sclk_c, sclk, frame_n_c,
			frame_n}),
		.sync_out(pins_sync)
	);

	// Differential clock and data read as true AND NOT complement, frame as true OR NOT complement; single-ended uses true line
	always @* begin
		if (strap_reg) begin
			frame_s = pins_sync[0] | ~pins_sync[1];
			sclk_s  = pins_sync[2] & ~pins_sync[3];
			sdi_s   = pins_sync[4] & ~pins_sync[5];
		end else begin
			frame_s = pins_sync[0];
			sclk_s  = pins_sync[2];
			sdi_s   = pins_sync[4];
		end
	end
	assign rst_s = pins_sync[6];

	assign sclk_fall  = sclk_d_reg & ~sclk_s;
	assign sclk_rise  = ~sclk_d_reg & sclk_s;
	assign frame_fall = frame_d_reg & ~frame_s;
	assign frame_rise = ~frame_d_reg & frame_s;
	assign rst_fall   = rst_d_reg & ~rst_s;
	assign cmd_addr   = shift_reg[`ADDR_MSB:`ADDR_LSB];
	assign cmd_read   = shift_reg[`READBACK_BIT];
	// A complete frame ends only when no reset pin fall arrives in the same cycle
	assign take_word  = (state_reg == ST_SHIFT) && (state_next == ST_BUSY);

	// Busy is open-drain: driven low only
	assign busy_n_out = 1'b0;
	assign busy_n_oe  = state_reg[0] | state_reg[3];

	// Next state; a reset pin fall wins over any frame event in the same cycle
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_INIT: begin
				if (rst_s && count_reg == 20'h00000) begin
					state_next = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (rst_fall) begin
					state_next = ST_INIT;
				end else if (frame_fall) begin
					state_next = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (rst_fall) begin
					state_next = ST_INIT;
				end else if (frame_rise) begin
					// A short frame is dropped without a busy pulse
					state_next = (bits_reg >= `WORD_BITS) ? ST_BUSY : ST_IDLE;
				end
			end
			ST_BUSY: begin
				if (rst_fall) begin
					state_next = ST_INIT;
				end else if (count_reg == 20'h00000) begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_INIT;
			end
		endcase
	end

	// State and edge history
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= ST_INIT;
			sclk_d_reg  <= 1'b0;
			frame_d_reg <= 1'b1;
			rst_d_reg   <= 1'b0;
		end else begin
			state_reg   <= state_next;
			sclk_d_reg  <= sclk_s;
			frame_d_reg <= frame_s;
			rst_d_reg   <= rst_s;
		end
	end

	// Strap is sampled throughout init, so a change during reset takes effect
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			strap_reg <= 1'b0;
		end else if (state_next == ST_INIT) begin
			strap_reg <= pins_sync[8];
		end
	end

	// Shift logic is enabled only inside a frame, keeping it quiet while idle
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			link_active_reg <= 1'b0;
		end else if (state_next == ST_SHIFT) begin
			link_active_reg <= 1'b1;
		end else begin
			link_active_reg <= 1'b0;
		end
	end

	// One down-counter serves both the init wait and the busy hold after a frame
	// Init holds while the pin stays low, then counts out the wait
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			count_reg <= 20'h00000;
		end else if (state_next == ST_INIT) begin
			if (state_reg != ST_INIT || !rst_s) begin
				count_reg <= INIT_CYCLES[19:0];
			end else if (count_reg != 20'h00000) begin
				count_reg <= count_reg - 20'h00001;
			end
		end else if (take_word) begin
			count_reg <= BUSY_CNT[19:0];
		end else if (state_reg == ST_BUSY && count_reg != 20'h00000) begin
			count_reg <= count_reg - 20'h00001;
		end
	end

	// The bit count saturates so over-long frames still count as complete
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			shift_reg <= 32'h00000000;
			bits_reg  <= 6'h00;
		end else if (state_reg == ST_IDLE && frame_fall) begin
			bits_reg <= 6'h00;
		end else if (link_active_reg && sclk_fall) begin
			shift_reg <= {shift_reg[`SHIFT_BITS-2:0], sdi_s};
			if (bits_reg != 6'h3f) begin
				bits_reg <= bits_reg + 6'h01;
			end
		end
	end

	// Readback: a read frame latches the word, the next frame shifts it out
	// Data changes on the rising link clock edge, ready for a falling-edge sample
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rd_pend_reg  <= 1'b0;
			rd_shift_reg <= 32'h00000000;
			sdo          <= 1'b0;
			sdo_c        <= 1'b1;
			sdo_oe       <= 1'b0;
		end else if (state_next == ST_INIT) begin
			rd_pend_reg <= 1'b0;
			sdo_oe      <= 1'b0;
		end else begin
			if (state_reg == ST_IDLE && frame_fall && rd_pend_reg) begin
				sdo_oe <= 1'b1;
				sdo    <= rd_shift_reg[`SHIFT_BITS-1];
				sdo_c  <= ~rd_shift_reg[`SHIFT_BITS-1];
			end
			if (state_reg == ST_SHIFT && sclk_rise && sdo_oe) begin
				rd_shift_reg <= {rd_shift_reg[`SHIFT_BITS-2:0], 1'b0};
				sdo          <= rd_shift_reg[`SHIFT_BITS-2];
				sdo_c        <= ~rd_shift_reg[`SHIFT_BITS-2];
			end
			if (state_reg == ST_SHIFT && frame_rise) begin
				sdo_oe      <= 1'b0;
				rd_pend_reg <= 1'b0;
			end
			if (take_word && cmd_read) begin
				rd_pend_reg  <= 1'b1;
				rd_shift_reg <= {10'h000, regs_mem[cmd_addr[1:0]]};
			end
		end
	end

	// Write port and register store; init reloads the gain and store defaults, while wr_addr and wr_data keep their values
	// Only four entries are stored, selected by the low address bits
	always @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			current_sense_gain <= `GAIN_RESET;
			wr_strobe          <= 1'b0;
			wr_addr            <= 7'h00;
			wr_data            <= 22'h000000;
			for (i = 0; i < `REG_COUNT; i = i + 1) begin
				regs_mem[i] <= `REG_RESET;
			end
		end else begin
			wr_strobe <= 1'b0;
			if (state_next == ST_INIT) begin
				current_sense_gain <= `GAIN_RESET;
				for (i = 0; i < `REG_COUNT; i = i + 1) begin
					regs_mem[i] <= `REG_RESET;
				end
			end else if (take_word && !cmd_read) begin
				wr_strobe <= 1'b1;
				wr_addr   <= cmd_addr;
				wr_data   <= shift_reg[`DATA_W-1:0];
				regs_mem[cmd_addr[1:0]] <= shift_reg[`DATA_W-1:0];
				if (cmd_addr == `GAIN_ADDR) begin
					current_sense_gain <= shift_reg[`GAIN_BIT];
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/host_link.sv ====
// Host side of the serial link: frames, clock bursts and data.
// Assumes a core clock to align frame starts off its edges.
`timescale 1ns/1ns
`default_nettype none
module host_link (
	input  wire logic core_clk,
	input  wire logic sdo,
	output logic      frame_n,
	output logic      frame_n_c,
	output logic      sclk,
	output logic      sclk_c,
	output logic      sdi,
	output logic      sdi_c
);
	logic [31:0] rx;
	assign frame_n_c = ~frame_n;
	assign sclk_c = ~sclk;
	assign sdi_c = ~sdi;
	initial begin
		frame_n = 1'b1;
		sclk = 1'b1;
		sdi = 1'b0;
		rx = 32'h00000000;
	end
	// Clock stands still between frames; data flips once released
	task automatic send(input logic [31:0] w, input int n);
		@(negedge core_clk) #1;
		frame_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			sdi = w[i];
			#62 sclk = 1'b0;
			// Readback taken at the falling edge; the slow link clock suits the weak driver
			rx = {rx[30:0], sdo};
			#63 sclk = 1'b1;
		end
		#62 frame_n = 1'b1;
		sdi = ~sdi;
	endtask
endmodule
`default_nettype wire

// ==== tb/pmu_serial_props.sv ====
// Checker for the serial write port and reset sequencer.
// Bound to the top design module; sees its ports only.
`timescale 1ns/1ns
`default_nettype none
module pmu_serial_props (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic frame_n,
	input wire logic reset_pin_n,
	input wire logic sdo_oe,
	input wire logic busy_n_oe,
	input wire logic current_sense_gain,
	input wire logic wr_strobe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_pin_busy_held: assert property (!reset_pin_n [*6] |-> busy_n_oe)
		else $error("busy released in pin reset");
	a_pin_sdo_off: assert property (!reset_pin_n [*6] |-> !sdo_oe)
		else $error("readback driven in pin reset");
	a_reset_no_write: assert property (!reset_pin_n |-> !wr_strobe)
		else $error("write taken in reset");
	a_write_at_rise: assert property (wr_strobe |-> frame_n && !$past(frame_n, 8))
		else $error("write not at frame end");
	a_strobe_single: assert property (wr_strobe |=> !wr_strobe)
		else $error("strobe too long");
	a_write_busy: assert property (wr_strobe |-> busy_n_oe)
		else $error("no busy on write");
	a_busy_length: assert property (wr_strobe |-> ##[26:29] $fell(busy_n_oe))
		else $error("busy length wrong");
	a_gain_by_write: assert property ($changed(current_sense_gain) && reset_pin_n
		|-> wr_strobe || $past(wr_strobe))
		else $error("gain moved without write");
	c_write: cover property (wr_strobe ##1 !current_sense_gain);
	c_pin_reset: cover property ($fell(reset_pin_n));
	c_busy_end: cover property ($fell(busy_n_oe));
	c_readback: cover property ($rose(sdo_oe));
endmodule
bind pmu_serial_write_and_reset pmu_serial_props u_props (.core_clk, .resetn, .frame_n,
	.reset_pin_n, .sdo_oe, .busy_n_oe, .current_sense_gain, .wr_strobe);
`default_nettype wire

// ==== tb/pmu_serial_write_and_reset_bench.sv ====
// Bench for the serial write port and reset sequencer.
// Host link model drives the pins; INIT_CYCLES cut to 50.
`timescale 1ns/1ns
`default_nettype none
module pmu_serial_write_and_reset_bench;
	localparam int INIT = 50;
	logic             core_clk = 1'b0;
	logic             resetn;
	logic             link_sel;
	logic             reset_pin_n;
	wire logic        frame_n, frame_n_c, sclk, sclk_c, sdi, sdi_c;
	wire logic        sdo, sdo_oe, busy_n_oe, gain, wr_strobe;
	wire logic [6:0]  wr_addr;
	wire logic [21:0] wr_data;
	int               failures = 0;
	int               n_tests = 0;
	int               cycles = 0;
	int               strobes = 0;
	logic [28:0]      last;
	always #5 core_clk = ~core_clk;
	pmu_serial_write_and_reset #(.INIT_CYCLES(INIT)) u_dut (.core_clk(core_clk),
		.resetn(resetn), .link_sel(link_sel), .frame_n(frame_n), .frame_n_c(frame_n_c),
		.sclk(sclk), .sclk_c(sclk_c), .sdi(sdi), .sdi_c(sdi_c), .sdo(sdo), .sdo_c(),
		.sdo_oe(sdo_oe), .reset_pin_n(reset_pin_n), .busy_n_in(~busy_n_oe),
		.busy_n_out(), .busy_n_oe(busy_n_oe), .current_sense_gain(gain),
		.wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data));
	host_link u_host (.core_clk(core_clk), .sdo(sdo), .frame_n(frame_n), .frame_n_c(frame_n_c),
		.sclk(sclk), .sclk_c(sclk_c), .sdi(sdi), .sdi_c(sdi_c));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic frame(input logic [31:0] w, input int n);
		u_host.send(w, n);
		settle(8);
		for (int i = 0; i < 40 && busy_n_oe !== 1'b0; i++) settle(1);
	endtask
	task automatic t_power_on;
		check(busy_n_oe, 1'b1);
		check(sdo_oe, 1'b0);
		check(gain, 1'b1);
		resetn = 1'b1;
		settle(INIT - 5);
		check(busy_n_oe, 1'b1);
		settle(15);
		check(busy_n_oe, 1'b0);
	endtask
	task automatic t_write;
		frame({3'h0, 7'h01, 22'h000000}, 29);
		check(strobes, 1);
		check(last, {7'h01, 22'h000000});
		check(gain, 1'b0);
		frame({3'h5, 7'h01, 22'h2c0a51}, 32);
		check(last, {7'h01, 22'h2c0a51});
		check(gain, 1'b1);
		frame({3'h0, 7'h41, 22'h000000}, 29);
		frame({3'h0, 7'h41, 22'h000000}, 32);
		check(u_host.rx, {10'h000, 22'h2c0a51});
		frame({3'h0, 7'h01, 22'h000000}, 28);
		check(strobes, 2);
		check(gain, 1'b1);
	endtask
	task automatic t_pin_reset;
		frame({3'h0, 7'h01, 22'h000000}, 29);
		reset_pin_n = 1'b0;
		link_sel = 1'b1;
		settle(10);
		check(gain, 1'b1);
		u_host.send({3'h0, 7'h01, 22'h000000}, 29);
		settle(8);
		check(strobes, 3);
		check(busy_n_oe, 1'b1);
		reset_pin_n = 1'b1;
		settle(INIT + 15);
		check(busy_n_oe, 1'b0);
		frame({3'h0, 7'h01, 22'h000000}, 29);
		check(gain, 1'b0);
	endtask
	task automatic conclude;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (wr_strobe === 1'b1) begin
			strobes++;
			last = {wr_addr, wr_data};
		end
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end
	initial begin
		resetn = 1'b0;
		link_sel = 1'b0;
		reset_pin_n = 1'b1;
		settle(16);
		t_power_on();
		t_write();
		t_pin_reset();
		conclude();
	end
endmodule
`default_nettype wire
